// ==== bench/cco_can_model.sv ====
// CAN controller model: takes offered frames and replays bus traffic
`timescale 1ns/1ps
module cco_can_model (
  input wire logic ref_clk_i,
  input wire logic stall_i,
  input wire logic tx_valid_i,
  input wire logic [10:0] tx_id_i,
  input wire logic [3:0] tx_dlc_i,
  input wire logic [63:0] tx_data_i,
  output logic tx_ready_o,
  output logic rx_valid_o,
  output logic [10:0] rx_id_o,
  output logic [3:0] rx_dlc_o,
  output logic [63:0] rx_data_o
);
  logic [10:0] got_id;
  logic [3:0] got_dlc;
  logic [63:0] got_data;
  int n_got;
  // Taking a frame never returns any reply to the block
  assign tx_ready_o = tx_valid_i & ~stall_i;
  always @(posedge ref_clk_i) begin
    if (tx_valid_i && tx_ready_o) begin
      got_id <= tx_id_i;
      got_dlc <= tx_dlc_i;
      got_data <= tx_data_i;
      n_got <= n_got + 1;
    end
  end
  initial begin
    n_got = 0;
    rx_valid_o = 1'b0;
    rx_id_o = 11'h7FF;
    rx_dlc_o = 4'h0;
    rx_data_o = 64'h0;
  end
  // Data lines invert after a frame so stale bytes cannot pass
  task automatic send(input logic [10:0] id, input logic [3:0] dlc, input logic [63:0] d);
    @(posedge ref_clk_i);
    rx_valid_o <= 1'b1;
    rx_id_o <= id;
    rx_dlc_o <= dlc;
    rx_data_o <= d;
    @(posedge ref_clk_i);
    rx_valid_o <= 1'b0;
    rx_data_o <= ~d;
  endtask
endmodule

// ==== bench/cco_top_test.sv ====
// Self-checking bench for the communication-object block
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module cco_top_test;
  logic ref_clk_i = 1'b0, nrst_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0, stall = 1'b0;
  logic [4:0] avs_address_i = 5'h00;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q;
  logic [3:0] avs_byteenable_i = 4'hF, app_tpdo_event_i = 4'h0, can_rx_dlc_i, can_tx_dlc_o;
  logic avs_waitrequest_o, can_rx_valid_i, can_tx_valid_o, can_tx_ready_i, sdo_seg_valid_o;
  logic [10:0] can_rx_id_i, can_tx_id_o;
  logic [63:0] can_rx_data_i, can_tx_data_o;
  logic [255:0] app_tpdo_data_i = {4{64'h0123456789ABCDEF}}, rpdo_data_o;
  logic [3:0] rpdo_valid_o;
  logic err_event_i = 1'b0;
  logic [15:0] err_code_i = 16'h0;
  logic [7:0] err_reg_i = 8'h0;
  logic [39:0] err_mfr_i = 40'h0;
  logic [55:0] sdo_seg_data_o;
  logic [2:0] sdo_seg_count_o;
  int n_mismatch = 0, checks_done = 0, s;
  int n_rpdo = 0, n_seg = 0;
  cco_top i_dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .can_rx_valid_i(can_rx_valid_i),
    .can_rx_id_i(can_rx_id_i), .can_rx_dlc_i(can_rx_dlc_i), .can_rx_data_i(can_rx_data_i),
    .can_tx_valid_o(can_tx_valid_o), .can_tx_ready_i(can_tx_ready_i),
    .can_tx_id_o(can_tx_id_o), .can_tx_dlc_o(can_tx_dlc_o), .can_tx_data_o(can_tx_data_o),
    .app_tpdo_data_i(app_tpdo_data_i), .app_tpdo_event_i(app_tpdo_event_i),
    .rpdo_data_o(rpdo_data_o), .rpdo_valid_o(rpdo_valid_o), .err_event_i(err_event_i),
    .err_code_i(err_code_i), .err_reg_i(err_reg_i), .err_mfr_i(err_mfr_i),
    .sdo_seg_valid_o(sdo_seg_valid_o), .sdo_seg_data_o(sdo_seg_data_o),
    .sdo_seg_count_o(sdo_seg_count_o));
  cco_can_model i_can (.ref_clk_i(ref_clk_i), .stall_i(stall), .tx_valid_i(can_tx_valid_o),
    .tx_id_i(can_tx_id_o), .tx_dlc_i(can_tx_dlc_o), .tx_data_i(can_tx_data_o),
    .tx_ready_o(can_tx_ready_i), .rx_valid_o(can_rx_valid_i), .rx_id_o(can_rx_id_i),
    .rx_dlc_o(can_rx_dlc_i), .rx_data_o(can_rx_data_i));
  always #10 ref_clk_i = ~ref_clk_i;
  // One-cycle strobes are counted so a missed or doubled pulse shows
  always @(posedge ref_clk_i) begin
    n_rpdo <= n_rpdo + int'(rpdo_valid_o[0]);
    n_seg <= n_seg + int'(sdo_seg_valid_o);
  end
  task automatic give_verdict(input bit timeout);
    if (timeout) n_mismatch++;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    for (k = 0; k < 20; k++) begin
      @(posedge ref_clk_i);
      if (avs_waitrequest_o === 1'b0) break;
    end
    if (k == 20) give_verdict(1);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task automatic wait_frame(input int n);
    int k;
    for (k = 0; k < 200 && i_can.n_got < n; k++) @(posedge ref_clk_i);
    if (k == 200) give_verdict(1);
  endtask
  initial begin
    repeat (3) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    bus(0, 5'h00, 32'h0);
    `CHK("ctrl", 32'h00000001, q)
    bus(0, 5'h14, 32'h0);
    `CHK("unmapped", 32'h0, q)
    i_can.send(11'h601, 4'h8, 64'h0000000000100740);
    wait_frame(1);
    `CHK("sdo id", 11'h581, i_can.got_id)
    `CHK("sdo up", 40'h0000000043, {i_can.got_data[63:32], i_can.got_data[7:0]})
    i_can.send(11'h601, 4'h8, 64'h0000000200100721);
    wait_frame(2);
    `CHK("dn init", 8'h60, i_can.got_data[7:0])
    i_can.send(11'h601, 4'h8, 64'h0000000000000010);
    wait_frame(3);
    `CHK("abort", 40'h0503000080, {i_can.got_data[63:32], i_can.got_data[7:0]})
    // Controller stalls while the emergency frame is offered
    stall <= 1'b1;
    err_code_i <= 16'h1234;
    err_reg_i <= 8'h5A;
    err_mfr_i <= 40'hA1A2A3A4A5;
    err_event_i <= 1'b1;
    @(posedge ref_clk_i);
    err_event_i <= 1'b0;
    repeat (5) @(posedge ref_clk_i);
    stall <= 1'b0;
    wait_frame(4);
    `CHK("emcy id", 15'h4081, {i_can.got_dlc, i_can.got_id})
    `CHK("emcy", 64'hA1A2A3A4A55A1234, i_can.got_data)
    i_can.send(11'h100, 4'h6, 64'h0000112233445566);
    repeat (30) @(posedge ref_clk_i);
    `CHK("quiet", 4, i_can.n_got)
    bus(1, 5'h00, 32'h00000101);
    bus(1, 5'h08, 32'hFFFFFF02);
    for (s = 1; s <= 4; s++) begin
      i_can.send(11'h080, 4'h0, 64'h0);
      repeat (8) @(posedge ref_clk_i);
      `CHK("pdo count", 4 + s / 2, i_can.n_got)
    end
    `CHK("pdo id", 11'h181, i_can.got_id)
    // Asynchronous TPDO1 with 12 mapped bits
    bus(1, 5'h0C, 32'h40400C40);
    app_tpdo_event_i <= 4'h2;
    @(posedge ref_clk_i);
    app_tpdo_event_i <= 4'h0;
    wait_frame(7);
    `CHK("async id", 15'h1281, {i_can.got_dlc, i_can.got_id})
    `CHK("async data", 64'h0000000000000DEF, i_can.got_data)
    i_can.send(11'h202, 4'h8, 64'h1122334455667788);
    i_can.send(11'h201, 4'h8, 64'h8877665544332211);
    i_can.send(11'h601, 4'h8, 64'h0000000200100721);
    wait_frame(8);
    i_can.send(11'h601, 4'h8, 64'h0000000000BBAA0B);
    wait_frame(9);
    `CHK("seg ack", 8'h20, i_can.got_data[7:0])
    `CHK("seg data", 59'h20000000000BBAA, {sdo_seg_count_o, sdo_seg_data_o})
    i_can.send(11'h601, 4'h8, 64'h00000000001007C0);
    wait_frame(10);
    `CHK("blk init", 16'h7FA0, {i_can.got_data[39:32], i_can.got_data[7:0]})
    i_can.send(11'h601, 4'h8, 64'h0706050403020181);
    wait_frame(11);
    `CHK("blk ack", 24'h7F01A2, i_can.got_data[23:0])
    i_can.send(11'h601, 4'h8, 64'h00000000000000C1);
    wait_frame(12);
    `CHK("blk end", 8'hA1, i_can.got_data[7:0])
    `CHK("rx pulses", 64'h0000000100000002, {n_rpdo, n_seg})
    `CHK("rpdo", 64'h8877665544332211, rpdo_data_o[63:0])
    give_verdict(0);
  end
endmodule

// ==== src/cco_cfg.svh ====
// Constants of the protocol-layer block: identifiers, specifiers, offsets and reset values
`ifndef CCO_CFG_SVH
`define CCO_CFG_SVH

// ----------------------------------------------------------------
// Object counts and identifier scheme
// ----------------------------------------------------------------
`define CCO_NPDO 4
`define CCO_FC_EMCY 4'h1
`define CCO_FC_TPDO 4'h3
`define CCO_FC_RPDO 4'h4
`define CCO_FC_STEP 4'h2
`define CCO_FC_SDO_TX 4'hB
`define CCO_FC_SDO_RX 4'hC
`define CCO_SYNC_ID 11'h080
`define CCO_TSTAMP_ID 11'h100

// ----------------------------------------------------------------
// Transmission types and sizes
// ----------------------------------------------------------------
`define CCO_TT_ACYC 8'h00
`define CCO_TT_CYC_MAX 8'hF0
`define CCO_TT_ASYNC_MIN 8'hFE
`define CCO_MAX_BITS 7'h40
`define CCO_BLK_MAX 7'h7F
`define CCO_DLC_FULL 4'h8

// ----------------------------------------------------------------
// Command specifiers (byte 0) and abort codes
// ----------------------------------------------------------------
`define CCO_CCS_SEG_DN 3'h0
`define CCO_CCS_INIT_DN 3'h1
`define CCO_CCS_INIT_UP 3'h2
`define CCO_CCS_ABORT 3'h4
`define CCO_CCS_BLK_DN 3'h6
`define CCO_CS_DN_INIT_RSP 8'h60
`define CCO_CS_DN_SEG_RSP 8'h20
`define CCO_CS_UP_EXP_RSP 8'h43
`define CCO_CS_BLK_INIT_RSP 8'hA0
`define CCO_CS_BLK_END_RSP 8'hA1
`define CCO_CS_BLK_ACK 8'hA2
`define CCO_CS_ABORT 8'h80
`define CCO_AB_TOGGLE 32'h05030000
`define CCO_AB_BAD_CS 32'h05040001
`define CCO_AB_BAD_SEQ 32'h05040003
`define CCO_AB_RO 32'h06010002
`define CCO_AB_NO_OBJ 32'h06020000

// ----------------------------------------------------------------
// Dictionary entries served by the SDO server
// ----------------------------------------------------------------
`define CCO_IDX_ERR_REG 16'h1001
`define CCO_IDX_WINDOW 16'h1007
`define CCO_IDX_RPDO_COM 16'h1400
`define CCO_IDX_TPDO_COM 16'h1800

// ----------------------------------------------------------------
// Register offsets (word indices on address bits 4:2) and reset values
// ----------------------------------------------------------------
`define CCO_REG_CTRL 3'h0
`define CCO_REG_WINDOW 3'h1
`define CCO_REG_TTYPE 3'h2
`define CCO_REG_MAPLEN 3'h3
`define CCO_REG_STATUS 3'h4
`define CCO_DEF_NODE 7'h01
`define CCO_DEF_WIN 16'h0000
`define CCO_DEF_TT 8'hFF
`define CCO_DEF_MAP 7'h40

`endif

// ==== src/cco_pkg.sv ====
// Types of the protocol-layer block
`include "cco_cfg.svh"
package cco_pkg;

  typedef enum logic [1:0] {SDO_IDLE, SDO_SEG_DN, SDO_BLK_DN, SDO_BLK_END} cco_sdo_st_t;

  typedef struct packed {
    logic [6:0] node_id;
    logic pdo_en;
    logic [15:0] win_len;
    logic [31:0] ttype;
    logic [27:0] maplen;
    logic [43:0] rpdo_id;
    logic [31:0] sync_cnt;
    logic [15:0] win_cnt;
    logic win_open;
    logic [3:0] sync_due;
    logic [3:0] async_due;
    logic [3:0] acyc_arm;
    logic emcy_pend;
    logic [63:0] emcy_data;
    logic [7:0] emcy_cnt;
    cco_sdo_st_t sdo_st;
    logic toggle;
    logic [6:0] blk_seq;
    logic resp_pend;
    logic [63:0] resp_data;
    logic tx_valid;
    logic [10:0] tx_id;
    logic [3:0] tx_dlc;
    logic [63:0] tx_data;
    logic [255:0] rpdo_data;
    logic [3:0] rpdo_valid;
    logic seg_valid;
    logic [55:0] seg_data;
    logic [2:0] seg_cnt;
    logic bus_ack;
    logic [31:0] rdata;
  } cco_state_t;

endpackage

// ==== src/cco_top.sv ====
// CANopen communication objects: PDO, SDO server, SYNC consumer, emergency producer
`timescale 1ns/1ps
`include "cco_cfg.svh"
module cco_top (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic can_rx_valid_i,
  input wire logic [10:0] can_rx_id_i,
  input wire logic [3:0] can_rx_dlc_i,
  input wire logic [63:0] can_rx_data_i,
  output logic can_tx_valid_o,
  input wire logic can_tx_ready_i,
  output logic [10:0] can_tx_id_o,
  output logic [3:0] can_tx_dlc_o,
  output logic [63:0] can_tx_data_o,
  input wire logic [255:0] app_tpdo_data_i,
  input wire logic [3:0] app_tpdo_event_i,
  output logic [255:0] rpdo_data_o,
  output logic [3:0] rpdo_valid_o,
  input wire logic err_event_i,
  input wire logic [15:0] err_code_i,
  input wire logic [7:0] err_reg_i,
  input wire logic [39:0] err_mfr_i,
  output logic sdo_seg_valid_o,
  output logic [55:0] sdo_seg_data_o,
  output logic [2:0] sdo_seg_count_o
);

  localparam cco_pkg::cco_state_t ST_RST = '{
    node_id: `CCO_DEF_NODE,
    win_len: `CCO_DEF_WIN,
    ttype: {4{`CCO_DEF_TT}},
    maplen: {4{`CCO_DEF_MAP}},
    rpdo_id: {4'(`CCO_FC_RPDO + 3 * `CCO_FC_STEP), `CCO_DEF_NODE,
              4'(`CCO_FC_RPDO + 2 * `CCO_FC_STEP), `CCO_DEF_NODE,
              4'(`CCO_FC_RPDO + `CCO_FC_STEP), `CCO_DEF_NODE,
              `CCO_FC_RPDO, `CCO_DEF_NODE},
    sdo_st: cco_pkg::SDO_IDLE,
    default: '0
  };

  cco_pkg::cco_state_t s_r;
  cco_pkg::cco_state_t s_nxt;

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Receive decode
  // ----------------------------------------------------------------
  logic sync_rx;
  logic sdo_rx;
  logic [2:0] ccs;
  logic [23:0] mux;
  assign sync_rx = can_rx_valid_i && (can_rx_id_i == `CCO_SYNC_ID) && s_r.pdo_en;
  assign sdo_rx = can_rx_valid_i && (can_rx_id_i == {`CCO_FC_SDO_RX, s_r.node_id});
  // Time stamp frames match no decoder here, so they fall through unused
  assign ccs = can_rx_data_i[7:5];
  assign mux = can_rx_data_i[31:8];

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] tt;
    logic [6:0] len;
    logic [7:0] len_sum;
    logic [63:0] mask;
    logic [15:0] idx;
    logic [7:0] sub;
    logic [1:0] k;
    logic hit;
    logic ro;
    logic [31:0] rval;
    logic [31:0] wd;
    logic loaded;
    tt = '0;
    len = '0;
    len_sum = '0;
    mask = '0;
    idx = can_rx_data_i[23:8];
    sub = can_rx_data_i[31:24];
    k = idx[1:0];
    hit = 1'b0;
    ro = 1'b0;
    rval = '0;
    wd = '0;
    loaded = 1'b0;
    s_nxt = s_r;
    s_nxt.rpdo_valid = '0;
    s_nxt.seg_valid = 1'b0;
    s_nxt.bus_ack = 1'b0;

    // Controller took the frame: done, no remote confirmation is awaited
    if (s_r.tx_valid && can_tx_ready_i) begin
      s_nxt.tx_valid = 1'b0;
    end

    // Window length 0 keeps the window open until the next SYNC
    if (sync_rx) begin
      s_nxt.win_cnt = s_r.win_len;
      s_nxt.win_open = 1'b1;
    end else if (s_r.win_open && (s_r.win_len != '0)) begin
      if (s_r.win_cnt <= 16'h0001) begin
        s_nxt.win_open = 1'b0;
        s_nxt.win_cnt = '0;
        s_nxt.sync_due = '0;
      end else begin
        s_nxt.win_cnt = s_r.win_cnt - 16'h0001;
      end
    end

    for (int i = 0; i < `CCO_NPDO; i++) begin
      tt = s_r.ttype[8*i +: 8];
      if (sync_rx) begin
        if (tt == `CCO_TT_ACYC) begin
          s_nxt.sync_due[i] = s_r.acyc_arm[i];
          s_nxt.acyc_arm[i] = 1'b0;
        end else if (tt <= `CCO_TT_CYC_MAX) begin
          if (s_r.sync_cnt[8*i +: 8] + 8'h01 >= tt) begin
            s_nxt.sync_due[i] = 1'b1;
            s_nxt.sync_cnt[8*i +: 8] = '0;
          end else begin
            s_nxt.sync_cnt[8*i +: 8] = s_r.sync_cnt[8*i +: 8] + 8'h01;
          end
        end
      end
      // An event in the clearing cycle still arms
      if (app_tpdo_event_i[i] && s_r.pdo_en) begin
        if (tt == `CCO_TT_ACYC) begin
          s_nxt.acyc_arm[i] = 1'b1;
        end else if (tt >= `CCO_TT_ASYNC_MIN) begin
          s_nxt.async_due[i] = 1'b1;
        end
      end
      if (can_rx_valid_i && s_r.pdo_en && (can_rx_id_i == s_r.rpdo_id[11*i +: 11])) begin
        s_nxt.rpdo_data[64*i +: 64] = can_rx_data_i;
        s_nxt.rpdo_valid[i] = 1'b1;
      end
    end

    // ----------------------------------------------------------------
    // Transmit arbitration: emergency, SDO answer, then the lowest-index due PDO, sync or async alike
    // ----------------------------------------------------------------
    if (!s_r.tx_valid) begin
      if (s_r.emcy_pend) begin
        s_nxt.tx_valid = 1'b1;
        s_nxt.tx_id = {`CCO_FC_EMCY, s_r.node_id};
        s_nxt.tx_dlc = `CCO_DLC_FULL;
        s_nxt.tx_data = s_r.emcy_data;
        s_nxt.emcy_pend = 1'b0;
        s_nxt.emcy_cnt = s_r.emcy_cnt + 8'h01;
      end else if (s_r.resp_pend) begin
        s_nxt.tx_valid = 1'b1;
        s_nxt.tx_id = {`CCO_FC_SDO_TX, s_r.node_id};
        s_nxt.tx_dlc = `CCO_DLC_FULL;
        s_nxt.tx_data = s_r.resp_data;
        s_nxt.resp_pend = 1'b0;
      end else begin
        for (int i = 0; i < `CCO_NPDO; i++) begin
          if (!loaded && ((s_r.sync_due[i] && s_r.win_open) || s_r.async_due[i])) begin
            loaded = 1'b1;
            len = s_r.maplen[7*i +: 7];
            len_sum = {1'b0, len} + 8'h07;
            mask = (len >= `CCO_MAX_BITS) ? {64{1'b1}} : ((64'h1 << len) - 64'h1);
            s_nxt.tx_valid = 1'b1;
            s_nxt.tx_id = {4'(`CCO_FC_TPDO + 4'(i) * `CCO_FC_STEP), s_r.node_id};
            s_nxt.tx_dlc = (len >= `CCO_MAX_BITS) ? `CCO_DLC_FULL : len_sum[6:3];
            s_nxt.tx_data = app_tpdo_data_i[64*i +: 64] & mask;
            s_nxt.sync_due[i] = 1'b0;
            s_nxt.async_due[i] = app_tpdo_event_i[i] && (s_r.ttype[8*i +: 8] >= 8'hFE);
          end
        end
      end
    end

    // New error event after (or during) the send of the last one
    if (err_event_i) begin
      s_nxt.emcy_pend = 1'b1;
      s_nxt.emcy_data = {err_mfr_i, err_reg_i, err_code_i};
    end

    if (!s_r.pdo_en) begin
      s_nxt.sync_due = '0;
      s_nxt.async_due = '0;
      s_nxt.acyc_arm = '0;
    end

    // ----------------------------------------------------------------
    // SDO server
    // ----------------------------------------------------------------
    if ((idx == `CCO_IDX_ERR_REG) && (sub == 8'h00)) begin
      hit = 1'b1;
      ro = 1'b1;
      rval = {24'h000000, err_reg_i};
    end else if ((idx == `CCO_IDX_WINDOW) && (sub == 8'h00)) begin
      hit = 1'b1;
      rval = {16'h0000, s_r.win_len};
    end else if ((idx[15:2] == 14'(`CCO_IDX_RPDO_COM >> 2)) && (sub == 8'h01)) begin
      hit = 1'b1;
      rval = {21'h0, s_r.rpdo_id[11*k +: 11]};
    end else if ((idx[15:2] == 14'(`CCO_IDX_TPDO_COM >> 2)) && (sub == 8'h02)) begin
      hit = 1'b1;
      rval = {24'h000000, s_r.ttype[8*k +: 8]};
    end
    wd = can_rx_data_i[63:32];

    if (sdo_rx) begin
      s_nxt.resp_pend = 1'b1;
      s_nxt.resp_data = {`CCO_AB_BAD_CS, mux, `CCO_CS_ABORT};
      if ((ccs == `CCO_CCS_ABORT) && (s_r.sdo_st != cco_pkg::SDO_BLK_DN)) begin
        s_nxt.resp_pend = 1'b0;
        s_nxt.sdo_st = cco_pkg::SDO_IDLE;
      end else begin
        unique case (s_r.sdo_st)
          cco_pkg::SDO_IDLE: begin
            if (ccs == `CCO_CCS_INIT_DN) begin
              if (!hit) begin
                s_nxt.resp_data = {`CCO_AB_NO_OBJ, mux, `CCO_CS_ABORT};
              end else if (can_rx_data_i[1]) begin
                s_nxt.resp_data = {32'h00000000, mux, `CCO_CS_DN_INIT_RSP};
                if (ro) begin
                  s_nxt.resp_data = {`CCO_AB_RO, mux, `CCO_CS_ABORT};
                end else if (idx == `CCO_IDX_WINDOW) begin
                  s_nxt.win_len = wd[15:0];
                end else if (idx[15:12] == 4'h1 && idx[11] == 1'b0) begin
                  s_nxt.rpdo_id[11*k +: 11] = wd[10:0];
                end else begin
                  s_nxt.ttype[8*k +: 8] = wd[7:0];
                end
              end else begin
                s_nxt.resp_data = {32'h00000000, mux, `CCO_CS_DN_INIT_RSP};
                s_nxt.sdo_st = cco_pkg::SDO_SEG_DN;
                s_nxt.toggle = 1'b0;
              end
            end else if (ccs == `CCO_CCS_INIT_UP) begin
              s_nxt.resp_data = hit ? {rval, mux, `CCO_CS_UP_EXP_RSP}
                                    : {`CCO_AB_NO_OBJ, mux, `CCO_CS_ABORT};
            end else if ((ccs == `CCO_CCS_BLK_DN) && !can_rx_data_i[0]) begin
              s_nxt.resp_data = {24'h000000, 1'b0, `CCO_BLK_MAX, mux, `CCO_CS_BLK_INIT_RSP};
              s_nxt.sdo_st = cco_pkg::SDO_BLK_DN;
              s_nxt.blk_seq = 7'h01;
            end
          end
          cco_pkg::SDO_SEG_DN: begin
            if (ccs != `CCO_CCS_SEG_DN) begin
              s_nxt.sdo_st = cco_pkg::SDO_IDLE;
            end else if (can_rx_data_i[4] != s_r.toggle) begin
              s_nxt.resp_data = {`CCO_AB_TOGGLE, 24'h000000, `CCO_CS_ABORT};
              s_nxt.sdo_st = cco_pkg::SDO_IDLE;
            end else begin
              s_nxt.seg_valid = 1'b1;
              s_nxt.seg_data = can_rx_data_i[63:8];
              s_nxt.seg_cnt = 3'h7 - can_rx_data_i[3:1];
              s_nxt.resp_data = {56'h0, `CCO_CS_DN_SEG_RSP | {3'h0, s_r.toggle, 4'h0}};
              s_nxt.toggle = !s_r.toggle;
              if (can_rx_data_i[0]) begin
                s_nxt.sdo_st = cco_pkg::SDO_IDLE;
              end
            end
          end
          cco_pkg::SDO_BLK_DN: begin
            if (can_rx_data_i[7:0] == `CCO_CS_ABORT) begin
              s_nxt.resp_pend = 1'b0;
              s_nxt.sdo_st = cco_pkg::SDO_IDLE;
            end else if (can_rx_data_i[6:0] != s_r.blk_seq) begin
              s_nxt.resp_data = {`CCO_AB_BAD_SEQ, 24'h000000, `CCO_CS_ABORT};
              s_nxt.sdo_st = cco_pkg::SDO_IDLE;
            end else begin
              s_nxt.seg_valid = 1'b1;
              s_nxt.seg_data = can_rx_data_i[63:8];
              s_nxt.seg_cnt = 3'h7;
              if (can_rx_data_i[7] || (s_r.blk_seq == `CCO_BLK_MAX)) begin
                // One acknowledge for the whole block
                s_nxt.resp_data = {40'h0, 1'b0, `CCO_BLK_MAX, 1'b0, s_r.blk_seq,
                                   `CCO_CS_BLK_ACK};
                s_nxt.blk_seq = 7'h01;
                if (can_rx_data_i[7]) begin
                  s_nxt.sdo_st = cco_pkg::SDO_BLK_END;
                end
              end else begin
                s_nxt.resp_pend = 1'b0;
                s_nxt.blk_seq = s_r.blk_seq + 7'h01;
              end
            end
          end
          cco_pkg::SDO_BLK_END: begin
            s_nxt.sdo_st = cco_pkg::SDO_IDLE;
            if ((ccs == `CCO_CCS_BLK_DN) && can_rx_data_i[0]) begin
              s_nxt.resp_data = {56'h0, `CCO_CS_BLK_END_RSP};
            end
          end
        endcase
      end
    end

    // ----------------------------------------------------------------
    // Avalon-MM slave: one wait state, read captured first, write on ack
    // ----------------------------------------------------------------
    if ((avs_read_i || avs_write_i) && !s_r.bus_ack) begin
      s_nxt.bus_ack = 1'b1;
      unique case (avs_address_i[4:2])
        `CCO_REG_CTRL: s_nxt.rdata = {23'h0, s_r.pdo_en, 1'b0, s_r.node_id};
        `CCO_REG_WINDOW: s_nxt.rdata = {16'h0, s_r.win_len};
        `CCO_REG_TTYPE: s_nxt.rdata = s_r.ttype;
        `CCO_REG_MAPLEN: s_nxt.rdata = {1'b0, s_r.maplen[27:21], 1'b0, s_r.maplen[20:14],
                                        1'b0, s_r.maplen[13:7], 1'b0, s_r.maplen[6:0]};
        `CCO_REG_STATUS: s_nxt.rdata = {err_reg_i, s_r.emcy_cnt, 5'h00, s_r.win_open,
                                        s_r.sync_due, 2'h0, s_r.sdo_st, s_r.toggle, s_r.emcy_pend};
        default: s_nxt.rdata = '0;
      endcase
    end
    if (avs_write_i && s_r.bus_ack) begin
      wd = be_merge(s_nxt.rdata, avs_writedata_i, avs_byteenable_i);
      unique case (avs_address_i[4:2])
        `CCO_REG_CTRL: begin
          s_nxt.node_id = wd[6:0];
          s_nxt.pdo_en = wd[8];
        end
        `CCO_REG_WINDOW: s_nxt.win_len = wd[15:0];
        `CCO_REG_TTYPE: s_nxt.ttype = wd;
        `CCO_REG_MAPLEN: s_nxt.maplen = {wd[30:24], wd[22:16], wd[14:8], wd[6:0]};
        default: s_nxt.win_len = s_nxt.win_len;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_r <= ST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !s_r.bus_ack;
  assign avs_readdata_o = s_r.rdata;
  assign can_tx_valid_o = s_r.tx_valid;
  assign can_tx_id_o = s_r.tx_id;
  assign can_tx_dlc_o = s_r.tx_dlc;
  assign can_tx_data_o = s_r.tx_data;
  assign rpdo_data_o = s_r.rpdo_data;
  assign rpdo_valid_o = s_r.rpdo_valid;
  assign sdo_seg_valid_o = s_r.seg_valid;
  assign sdo_seg_data_o = s_r.seg_data;
  assign sdo_seg_count_o = s_r.seg_cnt;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  tx_no_confirm_a: assert property (can_tx_valid_o && can_tx_ready_i |=> !can_tx_valid_o)
    else $error("frame held after controller accepted it");
  tx_hold_a: assert property (can_tx_valid_o && !can_tx_ready_i
      |=> can_tx_valid_o && $stable(can_tx_id_o) && $stable(can_tx_data_o))
    else $error("frame changed before acceptance");
  sync_in_win_a: assert property ($rose(can_tx_valid_o) &&
      (can_tx_id_o[10:7] == `CCO_FC_TPDO) && (s_r.ttype[7:0] <= `CCO_TT_CYC_MAX)
      |-> $past(s_r.win_open))
    else $error("synchronous PDO sent outside window");
  cyc_on_sync_a: assert property ($rose(s_r.sync_due[0]) |-> $past(sync_rx))
    else $error("cyclic PDO due without SYNC");
  emcy_once_a: assert property (can_tx_valid_o && can_tx_ready_i &&
      (can_tx_id_o == {`CCO_FC_EMCY, s_r.node_id}) && !err_event_i && !s_r.emcy_pend
      |=> !s_r.emcy_pend ##1 (!s_r.emcy_pend || $past(err_event_i)))
    else $error("second emergency without new error");
  emcy_layout_a: assert property (can_tx_valid_o && (can_tx_id_o[10:7] == `CCO_FC_EMCY)
      |-> can_tx_dlc_o == `CCO_DLC_FULL)
    else $error("emergency frame not eight bytes");
  dlc_max_a: assert property (can_tx_valid_o |-> can_tx_dlc_o <= `CCO_DLC_FULL)
    else $error("frame longer than eight bytes");
  no_tstamp_a: assert property (can_tx_valid_o |-> can_tx_id_o != `CCO_TSTAMP_ID)
    else $error("time stamp identifier produced");
  rpdo_match_a: assert property (rpdo_valid_o[0] |->
      $past(can_rx_id_i) == $past(s_r.rpdo_id[10:0]))
    else $error("receive PDO took a foreign identifier");
  toggle_abort_a: assert property (sdo_rx && (s_r.sdo_st == cco_pkg::SDO_SEG_DN) &&
      (ccs == `CCO_CCS_SEG_DN) && (can_rx_data_i[4] != s_r.toggle)
      |=> (s_r.sdo_st == cco_pkg::SDO_IDLE) && (s_r.resp_data[7:0] == `CCO_CS_ABORT))
    else $error("toggle mismatch not aborted");
  blk_limit_a: assert property ((s_r.sdo_st == cco_pkg::SDO_BLK_DN) |->
      (s_r.blk_seq != 7'h00) && (s_r.blk_seq <= `CCO_BLK_MAX))
    else $error("block sequence out of range");
  // An answer must follow one cycle with a read or write request held in wait
  bus_wait_a: assert property ((avs_read_i || avs_write_i) && !avs_waitrequest_o
      |-> $past(avs_read_i || avs_write_i) && $past(avs_waitrequest_o))
    else $error("bus request answered without wait state");

  sync_pdo_c: cover property (sync_rx ##[1:20] ($rose(can_tx_valid_o) &&
      (can_tx_id_o[10:7] == `CCO_FC_TPDO)));
  seg_done_c: cover property (sdo_seg_valid_o && (s_r.sdo_st == cco_pkg::SDO_IDLE));
  emcy_sent_c: cover property (can_tx_valid_o && can_tx_ready_i &&
      (can_tx_id_o[10:7] == `CCO_FC_EMCY));
  blk_ack_c: cover property (s_r.resp_pend && (s_r.resp_data[7:0] == `CCO_CS_BLK_ACK));

endmodule
